// File: bench/board_supervisor.sv
// Board reset supervisor model
`timescale 1ns/100ps
`default_nettype none
module board_supervisor #(
  parameter int settle_cycles = 20
) (
  input wire logic core_clk_i,
  output logic sys_reset_n_o,
  output logic test_reset_n_o
);
  // Power-on state: reset held, test reset idle
  initial begin
    sys_reset_n_o = 1'h0;
    test_reset_n_o = 1'h1;
  end
  // Level changes only just after an edge
  task automatic hold(input logic lvl, input int n);
    sys_reset_n_o <= lvl;
    repeat (n) @(posedge core_clk_i);
  endtask
  // Double pulse with a test reset inside the first hold
  task automatic power_up(input int p1);
    test_reset_n_o <= 1'h0;
    repeat (3) @(posedge core_clk_i);
    test_reset_n_o <= 1'h1;
    hold(1'h0, settle_cycles + 10);
    hold(1'h1, p1);
    hold(1'h0, strap_pkg::pulse2_min_sclk + 4);
    sys_reset_n_o <= 1'h1;
  endtask
  // Short lengths are asked for on purpose to provoke a flag
  task automatic hot(input int n);
    hold(1'h0, n);
    sys_reset_n_o <= 1'h1;
  endtask
endmodule
`default_nettype wire

// File: bench/reset_strap_sequencer_tb.sv
// Testbench of the reset strap sequencer
`timescale 1ns/100ps
`default_nettype none
module reset_strap_sequencer_tb;
  logic core_clk_i, rst_n_i, sys_reset_n_i, test_reset_n_i, sysclk_freq_select_i;
  logic boot_memory_select_i, bus_master_indicator_i, link2_direction_i, timer0_expired_i;
  logic [2:0] core_clock_ratio_i, chip_position_id_i, output_impedance_select_i;
  logic [2:0] drive_strength_select_i;
  logic boot_memory_select_pd_o, boot_memory_select_pu_o, bus_master_indicator_pd_o;
  logic core_in_reset_o, boot_from_prom_o, await_external_boot_o, test_mode_strap_a_o;
  logic test_mode_strap_b_o, ratio_reserved_o, test_mode_violation_o, powerup_seq_ok_o;
  logic sequence_violation_o, static_pin_violation_o;
  logic [3:0] external_interrupt_enable_o, external_interrupt_edge_o, core_ratio_x2_o;
  int err_total, cmp_count, cycles;
  // Ratio times two per code; reserved falls back to the default
  logic [3:0] ratio_exp [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'h4};
  reset_strap_sequencer #(.settle_cycles(20)) uut (.*);
  board_supervisor #(.settle_cycles(20)) sup (.core_clk_i, .sys_reset_n_o(sys_reset_n_i),
    .test_reset_n_o(test_reset_n_i));
  // Clock of 100 ns period
  initial begin
    core_clk_i = 1'h0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Ceiling well above the 1200 cycles the tests need
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      end_sim();
    end
  end
  // Power-up, strap sweep over hot resets, then provoked violations
  initial begin
    rst_n_i = 1'h0;
    {timer0_expired_i, link2_direction_i} = 2'h0;
    {bus_master_indicator_i, boot_memory_select_i} = 2'h3;
    core_clock_ratio_i = 3'h5;
    chip_position_id_i = 3'h1;
    output_impedance_select_i = 3'h0;
    drive_strength_select_i = 3'h7;
    sysclk_freq_select_i = 1'h1;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'h1;
    @(posedge core_clk_i);
    sup.power_up(60);
    repeat (6) @(posedge core_clk_i);
    check({3'h0, powerup_seq_ok_o}, 4'h1);
    check({2'h0, boot_memory_select_pu_o, boot_memory_select_pd_o}, 4'h2);
    check({3'h0, await_external_boot_o}, 4'h1);
    check(external_interrupt_edge_o, 4'hf);
    check(core_ratio_x2_o, 4'ha);
    boot_memory_select_i <= 1'h0;
    repeat (4) @(posedge core_clk_i);
    check({3'h0, await_external_boot_o}, 4'h1);
    $display("power-up test done");
    for (int i = 0; i < 8; i++) begin
      fork
        sup.hot(110);
        begin
          repeat (4) @(posedge core_clk_i);
          check({1'h0, boot_memory_select_pd_o, bus_master_indicator_pd_o, core_in_reset_o},
                4'h7);
          {timer0_expired_i, link2_direction_i} <= {i == 7, i == 6};
          {bus_master_indicator_i, boot_memory_select_i} <= i[1:0];
          core_clock_ratio_i <= i[2:0];
        end
      join
      repeat (6) @(posedge core_clk_i);
      check({2'h0, await_external_boot_o, boot_from_prom_o}, {2'h0, i[0], !i[0]});
      check(external_interrupt_enable_o, {4{i[1]}});
      check(core_ratio_x2_o, ratio_exp[i]);
      check({3'h0, ratio_reserved_o}, {3'h0, i == 7});
      check({1'h0, test_mode_strap_a_o, test_mode_strap_b_o, test_mode_violation_o},
            {1'h0, i == 6, i == 7, i > 5});
    end
    check({3'h0, sequence_violation_o}, 4'h0);
    $display("hot reset test done");
    sup.hot(50);
    repeat (6) @(posedge core_clk_i);
    check({3'h0, sequence_violation_o}, 4'h1);
    check({3'h0, static_pin_violation_o}, 4'h0);
    chip_position_id_i <= 3'h2;
    repeat (4) @(posedge core_clk_i);
    check({3'h0, static_pin_violation_o}, 4'h1);
    $display("violation test done");
    end_sim();
  end
endmodule
`default_nettype wire

// File: bench/strap_props_properties.sv
// Checker of reset pin and strap output relations
`timescale 1ns/100ps
`default_nettype none
module strap_props #(
  parameter int settle_cycles = 20
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sys_reset_n_i,
  input wire logic boot_memory_select_pd_o,
  input wire logic boot_memory_select_pu_o,
  input wire logic bus_master_indicator_pd_o,
  input wire logic core_in_reset_o,
  input wire logic boot_from_prom_o,
  input wire logic await_external_boot_o,
  input wire logic [3:0] external_interrupt_enable_o,
  input wire logic [3:0] external_interrupt_edge_o,
  input wire logic sequence_violation_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Three cycles out of reset, so the captured registers have landed
  sequence s_run;
    !core_in_reset_o [*3];
  endsequence
  chk_pull_state: assert property (
    boot_memory_select_pd_o == core_in_reset_o && bus_master_indicator_pd_o == core_in_reset_o
    && boot_memory_select_pu_o != core_in_reset_o) else $error("pull state");
  chk_sync_enter: assert property (
    $fell(sys_reset_n_i) |-> ##[1:3] core_in_reset_o) else $error("late entry");
  chk_sync_leave: assert property (
    $rose(sys_reset_n_i) |-> ##[1:3] !core_in_reset_o) else $error("late exit");
  chk_sync_delay: assert property (
    core_in_reset_o == !$past(sys_reset_n_i, 2)) else $error("sync delay");
  chk_boot_idle: assert property (
    core_in_reset_o |-> !boot_from_prom_o && !await_external_boot_o) else $error("boot early");
  chk_boot_one: assert property (
    s_run |-> boot_from_prom_o != await_external_boot_o) else $error("boot mode");
  chk_irq_mode: assert property (
    s_run |-> external_interrupt_edge_o == external_interrupt_enable_o
    && (&external_interrupt_enable_o == |external_interrupt_enable_o)) else $error("irq mode");
  chk_strap_hold: assert property (
    s_run |-> $stable({await_external_boot_o, external_interrupt_enable_o}))
    else $error("strap moved");
  chk_err_sticky: assert property (
    sequence_violation_o |=> sequence_violation_o) else $error("flag dropped");
endmodule
bind reset_strap_sequencer strap_props #(.settle_cycles(settle_cycles)) chk (.core_clk_i,
  .rst_n_i, .sys_reset_n_i, .boot_memory_select_pd_o, .boot_memory_select_pu_o,
  .bus_master_indicator_pd_o, .core_in_reset_o, .boot_from_prom_o, .await_external_boot_o,
  .external_interrupt_enable_o, .external_interrupt_edge_o, .sequence_violation_o);
`default_nettype wire

// File: src/level_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
  parameter int width = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [width-1:0] async_i,
  output logic [width-1:0] sync_o
);
  typedef struct packed {
    logic [width-1:0] meta;
    logic [width-1:0] stable;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // Elaboration check: a synchroniser with no bits cannot be built
  if (width < 1) begin : g_width_check
    $error("level_sync width must be at least one");
  end

  // First stage feeds only the second stage
  always_comb begin
    state_next.meta = async_i;
    state_next.stable = state_reg.meta;
  end

  // Reset to the asserted level of active-low inputs would hide them, so reset to ones
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.stable;
endmodule
`default_nettype wire

// File: src/reset_strap_sequencer.sv
// Reset strap capture, reset sequence monitor and core clock ratio decode
//
// Overview of operation
// RULE1: Strap levels are sampled while reset is asserted and the captured values select modes.
// RULE2: An undriven strap reads as 0 because the pin default during reset is low.
// RULE3: Boot strap 0 boots from the external PROM at once, 1 idles awaiting an external boot.
// RULE4: Interrupt strap 0 leaves the four lines disabled and level, 1 enables them edge sensitive.
// RULE5: The board holds both test-mode straps at 0 in reset; 1 is reserved.
// RULE6: At power-up reset stays asserted 2 ms after supplies, clocks and straps settle.
// RULE7: The first power-up release pulse lasts 50 to 100 system clocks.
// RULE8: The second power-up assertion lasts at least 100 system clocks before final release.
// RULE9: Test reset is asserted at least 2 system clocks during power-up reset.
// RULE10: A hot reset is held at least 100 system clocks.
// RULE11: A hot reset is released no sooner than 2 ms after the straps settle.
// RULE12: Static configuration pins change only while reset is asserted.
// RULE13: During reset the boot-select and bus-master strap pins are pulled low internally.
// RULE14: Reset and test reset are synchronised inside the device.
// RULE15: Core clock ratio codes 000..110 give 2, 2.5, 3, 3.5, 4, 5, 6; 111 is reserved.
// RULE16: The boot-select pin has a pull-down during reset and a pull-up after release.
// RULE17: Captured straps are held from final release until reset is asserted again.
`timescale 1ns/100ps
`default_nettype none
module reset_strap_sequencer #(
  parameter int settle_cycles = strap_pkg::settle_cycles
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sys_reset_n_i,
  input wire logic test_reset_n_i,
  input wire logic boot_memory_select_i,
  input wire logic bus_master_indicator_i,
  input wire logic link2_direction_i,
  input wire logic timer0_expired_i,
  input wire logic [2:0] core_clock_ratio_i,
  input wire logic [2:0] chip_position_id_i,
  input wire logic [2:0] output_impedance_select_i,
  input wire logic [2:0] drive_strength_select_i,
  input wire logic sysclk_freq_select_i,
  output logic boot_memory_select_pd_o,
  output logic boot_memory_select_pu_o,
  output logic bus_master_indicator_pd_o,
  output logic core_in_reset_o,
  output logic boot_from_prom_o,
  output logic await_external_boot_o,
  output logic [3:0] external_interrupt_enable_o,
  output logic [3:0] external_interrupt_edge_o,
  output logic test_mode_strap_a_o,
  output logic test_mode_strap_b_o,
  output logic [3:0] core_ratio_x2_o,
  output logic ratio_reserved_o,
  output logic test_mode_violation_o,
  output logic powerup_seq_ok_o,
  output logic sequence_violation_o,
  output logic static_pin_violation_o
);
  typedef enum logic [2:0] {
    st_power_hold, st_pulse1, st_pulse2, st_running, st_hot_hold
  } seq_state_t;

  typedef struct packed {
    seq_state_t seq;
    logic [31:0] cnt;
    logic [2:0] trst_cnt;
    logic [strap_pkg::strap_width-1:0] straps;
    logic [9:0] statics;
    logic [3:0] ratio_x2;
    logic ratio_res;
    logic tm_viol;
    logic seq_ok;
    logic seq_viol;
    logic static_viol;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;
  logic [1:0] sync_lv;
  logic reset_act;
  logic trst_act;
  logic [strap_pkg::strap_width-1:0] strap_pins;
  logic [9:0] static_pins;
  logic [3:0] ratio_x2_dec;

  // Elaboration check: a zero settle time cannot be measured
  if (settle_cycles < 1) begin : g_settle_check
    $error("settle_cycles must be at least one");
  end

  // Board reset enters inverted so the synchroniser's reset-to-ones reads as reset held;
  // otherwise a false release would be seen just after power-on and flag the sequence
  level_sync #(
    .width(2)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({test_reset_n_i, !sys_reset_n_i}),
    .sync_o(sync_lv)
  ); // RULE14

  assign reset_act = sync_lv[0];
  assign trst_act = !sync_lv[1];
  assign strap_pins = {timer0_expired_i, link2_direction_i,
                       bus_master_indicator_i, boot_memory_select_i};
  assign static_pins = {sysclk_freq_select_i, drive_strength_select_i,
                        output_impedance_select_i, chip_position_id_i};

  // Ratio lookup; reserved code falls back to the lowest ratio
  always_comb begin
    unique case (core_clock_ratio_i)
      3'h0: ratio_x2_dec = strap_pkg::ratio_x2_000;
      3'h1: ratio_x2_dec = strap_pkg::ratio_x2_001;
      3'h2: ratio_x2_dec = strap_pkg::ratio_x2_010;
      3'h3: ratio_x2_dec = strap_pkg::ratio_x2_011;
      3'h4: ratio_x2_dec = strap_pkg::ratio_x2_100;
      3'h5: ratio_x2_dec = strap_pkg::ratio_x2_101;
      3'h6: ratio_x2_dec = strap_pkg::ratio_x2_110;
      default: ratio_x2_dec = strap_pkg::ratio_x2_000;
    endcase
  end

  // Sequence monitor, strap capture and static pin watch
  always_comb begin
    state_next = state_reg;
    if (reset_act) begin
      state_next.straps = strap_pins; // RULE1
      state_next.statics = static_pins;
      state_next.ratio_x2 = ratio_x2_dec; // RULE15
      state_next.ratio_res = (core_clock_ratio_i == strap_pkg::ratio_reserved_code);
      state_next.tm_viol = strap_pins[strap_pkg::tm_a_pos]
                         | strap_pins[strap_pkg::tm_b_pos]; // RULE5
    end else if (static_pins != state_reg.statics) begin
      state_next.static_viol = 1'b1; // RULE12
    end
    if (trst_act && state_reg.trst_cnt != 3'h7) begin
      state_next.trst_cnt = state_reg.trst_cnt + 3'h1;
    end
    if (state_reg.cnt != 32'hffffffff) begin
      state_next.cnt = state_reg.cnt + 32'h1;
    end
    unique case (state_reg.seq)
      st_power_hold: begin
        if (!reset_act) begin
          // RULE6
          if (state_reg.cnt < 32'(settle_cycles)) begin
            state_next.seq_viol = 1'b1;
          end
          state_next.seq = st_pulse1;
          state_next.cnt = 32'h1;
        end
      end
      st_pulse1: begin
        if (reset_act) begin
          state_next.seq = st_pulse2;
          state_next.cnt = 32'h1;
        end else if (state_reg.cnt >= 32'(strap_pkg::pulse1_max_sclk)) begin
          state_next.seq_viol = 1'b1; // RULE7
        end
        if (reset_act && state_reg.cnt < 32'(strap_pkg::pulse1_min_sclk)) begin
          state_next.seq_viol = 1'b1; // RULE7
        end
      end
      st_pulse2: begin
        if (!reset_act) begin
          state_next.seq = st_running;
          // RULE8 RULE9
          if (state_reg.cnt < 32'(strap_pkg::pulse2_min_sclk)
              || state_reg.trst_cnt < 3'(strap_pkg::trst_min_sclk)) begin
            state_next.seq_viol = 1'b1;
          end else if (!state_reg.seq_viol) begin
            state_next.seq_ok = 1'b1;
          end
        end
      end
      st_running: begin
        if (reset_act) begin
          state_next.seq = st_hot_hold;
          state_next.cnt = 32'h1;
        end
      end
      st_hot_hold: begin
        if (!reset_act) begin
          state_next.seq = st_running;
          // RULE10 RULE11
          if (state_reg.cnt < 32'(strap_pkg::hot_min_sclk)
              || state_reg.cnt < 32'(settle_cycles)) begin
            state_next.seq_viol = 1'b1;
          end
        end
      end
    endcase
  end

  // Power-on state; captured straps default low as the pull-downs dictate
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_reg.seq <= st_power_hold;
      state_reg.cnt <= 32'h0;
      state_reg.trst_cnt <= 3'h0;
      state_reg.straps <= {strap_pkg::strap_width{strap_pkg::strap_default}}; // RULE2
      state_reg.statics <= 10'h0;
      state_reg.ratio_x2 <= strap_pkg::ratio_x2_000;
      state_reg.ratio_res <= 1'b0;
      state_reg.tm_viol <= 1'b0;
      state_reg.seq_ok <= 1'b0;
      state_reg.seq_viol <= 1'b0;
      state_reg.static_viol <= 1'b0;
    end else begin
      state_reg <= state_next; // RULE17
    end
  end

  // Pin pulls follow the synchronised reset level
  assign boot_memory_select_pd_o = reset_act; // RULE13 RULE16
  assign boot_memory_select_pu_o = !reset_act; // RULE16
  assign bus_master_indicator_pd_o = reset_act; // RULE13
  assign core_in_reset_o = reset_act;
  // Mode outputs from the captured straps
  assign boot_from_prom_o = !reset_act
    && state_reg.straps[strap_pkg::boot_pos] == strap_pkg::boot_from_prom; // RULE3
  assign await_external_boot_o = !reset_act
    && state_reg.straps[strap_pkg::boot_pos] == strap_pkg::boot_from_host; // RULE3
  assign external_interrupt_enable_o =
    {4{state_reg.straps[strap_pkg::irq_pos] == strap_pkg::irq_edge_enabled}}; // RULE4
  assign external_interrupt_edge_o =
    {4{state_reg.straps[strap_pkg::irq_pos] == strap_pkg::irq_edge_enabled}}; // RULE4
  assign test_mode_strap_a_o = state_reg.straps[strap_pkg::tm_a_pos];
  assign test_mode_strap_b_o = state_reg.straps[strap_pkg::tm_b_pos];
  assign core_ratio_x2_o = state_reg.ratio_x2;
  assign ratio_reserved_o = state_reg.ratio_res;
  assign test_mode_violation_o = state_reg.tm_viol;
  assign powerup_seq_ok_o = state_reg.seq_ok;
  assign sequence_violation_o = state_reg.seq_viol;
  assign static_pin_violation_o = state_reg.static_viol;
endmodule
`default_nettype wire

// File: src/strap_pkg.sv
// Package with strap encodings, ratio table and reset timing counts
package strap_pkg;
  // Boot source strap levels
  localparam logic boot_from_prom = 1'h0;
  localparam logic boot_from_host = 1'h1;
  // Interrupt strap levels
  localparam logic irq_level_disabled = 1'h0;
  localparam logic irq_edge_enabled = 1'h1;
  // Reset value of every captured strap: the internal pull-down default
  localparam logic strap_default = 1'h0;
  // Positions in the packed strap vector
  localparam int strap_width = 4;
  localparam int boot_pos = 0;
  localparam int irq_pos = 1;
  localparam int tm_a_pos = 2;
  localparam int tm_b_pos = 3;
  // Clock ratio table in half steps: code -> ratio times two
  localparam logic [2:0] ratio_reserved_code = 3'h7;
  localparam logic [3:0] ratio_x2_000 = 4'h4;
  localparam logic [3:0] ratio_x2_001 = 4'h5;
  localparam logic [3:0] ratio_x2_010 = 4'h6;
  localparam logic [3:0] ratio_x2_011 = 4'h7;
  localparam logic [3:0] ratio_x2_100 = 4'h8;
  localparam logic [3:0] ratio_x2_101 = 4'ha;
  localparam logic [3:0] ratio_x2_110 = 4'hc;
  // Clock rate and reset sequence figures
  localparam int clk_period_ns = 100;
  localparam int pulse1_min_sclk = 50;
  localparam int pulse1_max_sclk = 100;
  localparam int pulse2_min_sclk = 100;
  localparam int hot_min_sclk = 100;
  localparam int trst_min_sclk = 2;
  localparam int settle_ms = 2;
  localparam int settle_cycles = (settle_ms * 1000000) / clk_period_ns;
  localparam int sync_stages = 2;
endpackage
